// ===== asy_core.sv
// Purpose: conversion pacing, sync/reset qualification, serial port control
// Assumes: filter delivers samples on i_sample_valid in the core domain
// Notes:   master clock is i_core_clk; serial clock is a second domain
`timescale 1ns/100ps
`include "asy_defs.svh"

// Notes on behaviour
// - serial clock low across 64 ready falls returns the interface to idle
// - serial input bits are sampled on the rising serial clock edge
// - each new output bit is launched on the falling serial clock edge
// - on ready assertion the result msb drives the output immediately
// - after a read command in run state a new result comes within one data period
// - fir path: first ready 62.98 periods plus 466 clocks after sync
// - continuous sync clock aligned to periods does not resynchronise
// - reset release: first ready 62.98046875 periods plus 468 clocks later
module asy_core #(
  parameter int unsigned DATA_PERIOD_CLKS = `ASY_CORE_CLK_HZ / `ASY_DATA_RATE_SPS,
  parameter int unsigned SINC_SYNC_CLKS   = `ASY_SINC_SYNC_CLKS
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_sclk,
  input  wire logic                   i_din,
  output logic                        o_dout,
  output logic                        o_conversion_ready_n,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_sync,
  input  wire logic                   i_fir_sel,
  input  wire logic                   i_cont_sync,
  input  wire logic [`ASY_WORD_W-1:0] i_sample_data,
  input  wire logic                   i_sample_valid,
  output logic [`ASY_CMD_W-1:0]       o_cmd_byte,
  output logic                        o_cmd_valid
);
  localparam logic [31:0] DP = 32'(DATA_PERIOD_CLKS);

  // settling count to the first ready, counted down to zero
  function automatic logic [31:0] settle(input logic [31:0] extra);
    settle = `ASY_DR_WHOLE * DP + ((DP * `ASY_DR_FRAC_NUM) >> `ASY_DR_FRAC_SHIFT) + extra - 32'h1;
  endfunction

  asy_link_if lk ();

  asy_link u_link (
    .i_sclk (i_sclk),
    .i_din  (i_din),
    .o_dout (o_dout),
    .lk     (lk.link)
  );

  asy_pkg::asy_state_e    state_reg;
  logic [31:0]            wait_cnt_reg;
  logic [31:0]            phase_cnt_reg;
  logic [31:0]            sph_cnt_reg;
  logic                   locked_reg;
  logic [2:0]             rstp_reg;
  logic [2:0]             syn_reg;
  logic [2:0]             sck_reg;
  logic [2:0]             ct_reg;
  logic [`ASY_WORD_W-1:0] latest_reg;
  logic [`ASY_WORD_W-1:0] word_reg;
  logic                   data_epoch_reg;
  logic                   idle_epoch_reg;
  logic                   link_rst_reg;
  logic                   ready_n_reg;
  logic                   cont_reg;
  logic                   rd_armed_reg;
  logic [6:0]             falls_reg;
  logic [`ASY_CMD_W-1:0]  cmd_byte_reg;
  logic                   cmd_valid_reg;
  logic                   conv;
  logic                   load;
  logic                   sync_edge;
  logic                   aligned;
  logic                   sync_accept;
  logic                   cmd_new;
  logic [31:0]            sync_delay;

  // pin synchronisers: stage 0 read only by stage 1
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rstp_reg <= 3'h0;
      syn_reg  <= 3'h0;
      sck_reg  <= 3'h0;
      ct_reg   <= 3'h0;
    end else begin
      rstp_reg <= {rstp_reg[1:0], i_reset_n};
      syn_reg  <= {syn_reg[1:0], i_sync};
      sck_reg  <= {sck_reg[1:0], i_sclk};
      ct_reg   <= {ct_reg[1:0], lk.cmd_tgl};
    end
  end

  // event decode
  assign sync_edge   = syn_reg[1] & ~syn_reg[2];
  assign aligned     = (sph_cnt_reg <= `ASY_SYNC_TOL) || (sph_cnt_reg >= DP - `ASY_SYNC_TOL);
  assign sync_accept = sync_edge && (state_reg != asy_pkg::ST_HOLD) && rstp_reg[1]
                       && !(i_cont_sync && locked_reg && aligned);
  assign sync_delay  = i_fir_sel ? settle(`ASY_SYNC_EXTRA_CLKS) : SINC_SYNC_CLKS - 32'h1;
  assign conv        = ((state_reg == asy_pkg::ST_WAIT) && (wait_cnt_reg == 32'h0))
                       || ((state_reg == asy_pkg::ST_RUN) && (phase_cnt_reg == DP - 32'h1));
  assign load        = conv && (cont_reg || rd_armed_reg);
  assign cmd_new     = ct_reg[1] ^ ct_reg[2];

  // conversion sequencer: hold, settle, run
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !rstp_reg[1]) begin
      state_reg     <= asy_pkg::ST_HOLD;
      wait_cnt_reg  <= 32'h0;
      phase_cnt_reg <= 32'h0;
    end else begin
      case (state_reg)
        asy_pkg::ST_HOLD: begin
          state_reg    <= asy_pkg::ST_WAIT;
          wait_cnt_reg <= settle(`ASY_RST_EXTRA_CLKS) - 32'h1;
        end
        asy_pkg::ST_WAIT: begin
          if (sync_accept) begin
            wait_cnt_reg <= sync_delay;
          end else if (wait_cnt_reg == 32'h0) begin
            state_reg     <= asy_pkg::ST_RUN;
            phase_cnt_reg <= 32'h0;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 32'h1;
          end
        end
        asy_pkg::ST_RUN: begin
          if (sync_accept) begin
            state_reg    <= asy_pkg::ST_WAIT;
            wait_cnt_reg <= sync_delay;
          end else begin
            phase_cnt_reg <= (phase_cnt_reg == DP - 32'h1) ? 32'h0 : phase_cnt_reg + 32'h1;
          end
        end
        default: state_reg <= asy_pkg::ST_HOLD;
      endcase
    end
  end

  // sync-clock phase tracker for continuous mode
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !rstp_reg[1]) begin
      sph_cnt_reg <= 32'h0;
      locked_reg  <= 1'b0;
    end else if (sync_accept) begin
      sph_cnt_reg <= 32'h1;
      locked_reg  <= i_cont_sync;
    end else begin
      sph_cnt_reg <= (sph_cnt_reg == DP - 32'h1) ? 32'h0 : sph_cnt_reg + 32'h1;
      locked_reg  <= locked_reg & i_cont_sync;
    end
  end

  // result capture, word hand-off and ready strobe
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      latest_reg     <= '0;
      word_reg       <= '0;
      data_epoch_reg <= 1'b0;
      ready_n_reg    <= 1'b1;
    end else begin
      if (i_sample_valid) begin
        latest_reg <= i_sample_data;
      end
      if (load) begin
        word_reg       <= i_sample_valid ? i_sample_data : latest_reg;
        data_epoch_reg <= ~data_epoch_reg;
        ready_n_reg    <= 1'b0;
      end else if ((sck_reg[1] && !sck_reg[2]) || (state_reg != asy_pkg::ST_RUN)
                   || (phase_cnt_reg == DP - `ASY_RDY_HIGH_LEAD)) begin
        ready_n_reg <= 1'b1;
      end
    end
  end

  // read mode and one-shot read request; a new request wins over the clear
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cont_reg     <= 1'b1;
      rd_armed_reg <= 1'b0;
    end else begin
      if (cmd_new && lk.cmd_byte == `ASY_CMD_RDATAC) begin
        cont_reg <= 1'b1;
      end else if (cmd_new && lk.cmd_byte == `ASY_CMD_SDATAC) begin
        cont_reg <= 1'b0;
      end
      if (cmd_new && lk.cmd_byte == `ASY_CMD_RDATA) begin
        rd_armed_reg <= 1'b1;
      end else if (load) begin
        rd_armed_reg <= 1'b0;
      end
    end
  end

  // idle detect: count ready falls while serial clock stays low
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || sck_reg[1]) begin
      falls_reg <= 7'h00;
    end else if (load) begin
      falls_reg <= (falls_reg == `ASY_IDLE_FALLS - 7'h01) ? 7'h00 : falls_reg + 7'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      idle_epoch_reg <= 1'b0;
      link_rst_reg   <= 1'b1;
    end else begin
      link_rst_reg <= 1'b0;
      if (!sck_reg[1] && load && falls_reg == `ASY_IDLE_FALLS - 7'h01) begin
        idle_epoch_reg <= ~idle_epoch_reg;
      end
    end
  end

  // received command bytes to the user side
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cmd_byte_reg  <= '0;
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= cmd_new;
      if (cmd_new) begin
        cmd_byte_reg <= lk.cmd_byte;
      end
    end
  end

  assign lk.word              = word_reg;
  assign lk.data_epoch        = data_epoch_reg;
  assign lk.idle_epoch        = idle_epoch_reg;
  assign lk.link_rst          = link_rst_reg;
  assign o_conversion_ready_n = ready_n_reg;
  assign o_cmd_byte           = cmd_byte_reg;
  assign o_cmd_valid          = cmd_valid_reg;

  // helper: cycles a read request has waited in run state
  logic [31:0] armed_cnt_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !rd_armed_reg || state_reg != asy_pkg::ST_RUN) begin
      armed_cnt_reg <= 32'h0;
    end else begin
      armed_cnt_reg <= armed_cnt_reg + 32'h1;
    end
  end

  sequence s_settle_start(logic [31:0] cnt);
    (state_reg == asy_pkg::ST_WAIT) && (wait_cnt_reg == cnt);
  endsequence

  property p_idle_reset;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (!sck_reg[1] && load && falls_reg == `ASY_IDLE_FALLS - 7'h01) |=> (idle_epoch_reg != $past(idle_epoch_reg));
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("interface not idled after 64 ready falls");

  property p_msb_ready;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      load |=> (!o_conversion_ready_n && (data_epoch_reg != $past(data_epoch_reg)));
  endproperty
  a_msb_ready: assert property (p_msb_ready) else $error("ready without new word flagged");

  property p_read_bound;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      rd_armed_reg |-> (armed_cnt_reg < DP + 32'h1);
  endproperty
  a_read_bound: assert property (p_read_bound) else $error("read request waited over one data period");

  property p_sync_fir;
    @(posedge i_core_clk) disable iff (i_sys_rst || !rstp_reg[1])
      (sync_accept && i_fir_sel) |=> s_settle_start(settle(`ASY_SYNC_EXTRA_CLKS));
  endproperty
  a_sync_fir: assert property (p_sync_fir) else $error("wrong settling after sync");

  property p_cont_hold;
    @(posedge i_core_clk) disable iff (i_sys_rst || !rstp_reg[1])
      (sync_edge && i_cont_sync && locked_reg && aligned && state_reg == asy_pkg::ST_RUN)
      |=> (state_reg == asy_pkg::ST_RUN);
  endproperty
  a_cont_hold: assert property (p_cont_hold) else $error("aligned sync clock edge resynchronised");

  property p_reset_release;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_reg == asy_pkg::ST_HOLD && rstp_reg[1]) |=> s_settle_start(settle(`ASY_RST_EXTRA_CLKS) - 32'h1);
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("wrong settling after reset release");

  property p_settle_end;
    @(posedge i_core_clk) disable iff (i_sys_rst || !rstp_reg[1])
      (s_settle_start(32'h0) ##0 (!sync_accept && cont_reg))
      |=> (state_reg == asy_pkg::ST_RUN) && !o_conversion_ready_n;
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("no ready at end of settling");
endmodule

// ===== asy_defs.svh
// Purpose: shared constants of the serial port and sync/reset timing block
// Assumes: master clock is the core clock
// Notes:   definitions only
`ifndef ASY_DEFS_SVH
`define ASY_DEFS_SVH
`define ASY_CORE_CLK_HZ     25000000
`define ASY_DATA_RATE_SPS   1000
`define ASY_WORD_W          32
`define ASY_CMD_W           8
`define ASY_IDLE_FALLS      7'h40
`define ASY_RST_EXTRA_CLKS  32'h000001D4
`define ASY_SYNC_EXTRA_CLKS 32'h000001D2
`define ASY_DR_WHOLE        32'h0000003E
`define ASY_DR_FRAC_NUM     32'h000000FB
`define ASY_DR_FRAC_SHIFT   8
`define ASY_SYNC_TOL        32'h00000002
`define ASY_SINC_SYNC_CLKS  32'h000003E8
`define ASY_RDY_HIGH_LEAD   32'h00000004
`define ASY_CMD_RDATAC      8'h10
`define ASY_CMD_SDATAC      8'h11
`define ASY_CMD_RDATA       8'h12
`endif

// ===== asy_pkg.sv
// Purpose: types of the serial port and sync/reset timing block
// Assumes: nothing
// Notes:   conversion sequencer states
package asy_pkg;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10
  } asy_state_e;
endpackage

// ===== asy_link_if.sv
// Purpose: carrier between core logic and serial-clock logic
// Assumes: core side owns word, epochs and link reset
// Notes:   epochs are toggles; link side owns command byte and toggle
`timescale 1ns/100ps
`include "asy_defs.svh"
interface asy_link_if;
  logic [`ASY_WORD_W-1:0] word;
  logic                   data_epoch;
  logic                   idle_epoch;
  logic                   link_rst;
  logic [`ASY_CMD_W-1:0]  cmd_byte;
  logic                   cmd_tgl;
  modport core (output word, output data_epoch, output idle_epoch, output link_rst,
                input cmd_byte, input cmd_tgl);
  modport link (input word, input data_epoch, input idle_epoch, input link_rst,
                output cmd_byte, output cmd_tgl);
endinterface

// ===== asy_link.sv
// Purpose: serial-clock side: command shift-in and data shift-out
// Assumes: word and epochs stay still around serial clock edges
// Notes:   epoch mismatch marks the start of a new frame
`timescale 1ns/100ps
`include "asy_defs.svh"
module asy_link (
  input  wire logic i_sclk,
  input  wire logic i_din,
  output logic      o_dout,
  asy_link_if.link  lk
);
  logic [`ASY_CMD_W-2:0] rx_sr_reg;
  logic [2:0]            rx_cnt_reg;
  logic                  rx_seen_reg;
  logic [`ASY_CMD_W-1:0] cmd_byte_reg;
  logic                  cmd_tgl_reg;
  logic [4:0]            tx_cnt_reg;
  logic                  tx_seen_reg;

  // command bits taken on the rising edge
  always_ff @(posedge i_sclk or posedge lk.link_rst) begin
    if (lk.link_rst) begin
      rx_sr_reg    <= '0;
      rx_cnt_reg   <= 3'h0;
      rx_seen_reg  <= 1'b0;
      cmd_byte_reg <= '0;
      cmd_tgl_reg  <= 1'b0;
    end else if (lk.idle_epoch != rx_seen_reg) begin
      rx_seen_reg <= lk.idle_epoch; // interface returned to idle
      rx_sr_reg   <= {6'h00, i_din};
      rx_cnt_reg  <= 3'h1;
    end else begin
      rx_sr_reg  <= {rx_sr_reg[5:0], i_din};
      rx_cnt_reg <= rx_cnt_reg + 3'h1;
      if (rx_cnt_reg == 3'h7) begin
        cmd_byte_reg <= {rx_sr_reg, i_din};
        cmd_tgl_reg  <= ~cmd_tgl_reg;
      end
    end
  end

  // output bit index advances on the falling edge
  always_ff @(negedge i_sclk or posedge lk.link_rst) begin
    if (lk.link_rst) begin
      tx_cnt_reg  <= 5'h00;
      tx_seen_reg <= 1'b0;
    end else if (lk.data_epoch != tx_seen_reg) begin
      tx_seen_reg <= lk.data_epoch;
      tx_cnt_reg  <= 5'h01;
    end else begin
      tx_cnt_reg <= tx_cnt_reg + 5'h01;
    end
  end

  // msb shows as soon as a new word is flagged, no edge needed
  assign o_dout      = (lk.data_epoch != tx_seen_reg) ? lk.word[`ASY_WORD_W-1] : lk.word[~tx_cnt_reg];
  assign lk.cmd_byte = cmd_byte_reg;
  assign lk.cmd_tgl  = cmd_tgl_reg;

  property p_rx_byte;
    @(posedge i_sclk) disable iff (lk.link_rst)
      (lk.idle_epoch == rx_seen_reg && rx_cnt_reg == 3'h7)
      |=> (cmd_byte_reg == {$past(rx_sr_reg), $past(i_din)}) && (cmd_tgl_reg != $past(cmd_tgl_reg));
  endproperty
  a_rx_byte: assert property (p_rx_byte) else $error("command byte not assembled from sampled bits");

  property p_tx_step;
    @(negedge i_sclk) disable iff (lk.link_rst)
      (lk.data_epoch == tx_seen_reg) |=> (tx_cnt_reg == $past(tx_cnt_reg) + 5'h01);
  endproperty
  a_tx_step: assert property (p_tx_step) else $error("output bit did not advance on falling edge");
endmodule

// ===== asy_host.sv
// Purpose: host model driving serial clock and command input
// Assumes: link clock of 48 ns paces the serial clock phases
// Notes:   serial clock stands low outside frames
`timescale 1ns/100ps
module asy_host (
  input  wire logic i_link_clk,
  input  wire logic i_dout,
  output logic      o_sclk,
  output logic      o_din
);
  initial begin
    o_sclk = 1'b0;
    o_din  = 1'b1;
  end
  // one bit, two link clocks per phase
  task automatic bit_xfer(input logic b, output logic s);
    o_din <= b;
    repeat (2) @(posedge i_link_clk);
    o_sclk <= 1'b1;
    @(posedge i_link_clk);
    s = i_dout;
    @(posedge i_link_clk);
    o_sclk <= 1'b0;
  endtask
  // top n bits of v, msb first
  task automatic send_byte(input logic [7:0] v, input int n);
    logic s;
    for (int i = 7; i > 7 - n; i--) bit_xfer(v[i], s);
    o_din <= ~v[8-n]; // released line shows the inverse
  endtask
  // quiet time after a command byte
  task automatic gap();
    repeat (20) @(posedge i_link_clk);
  endtask
  // 32 data bits, msb first
  task automatic read_word(output logic [31:0] w);
    logic s;
    for (int i = 31; i >= 0; i--) begin
      bit_xfer(1'b0, s);
      w[i] = s;
    end
  endtask
endmodule

// ===== tb.sv
// Purpose: self-checking bench of the serial port and sync/reset block
// Assumes: short data period of 64 clocks
// Notes:   expected latencies worked out from the period
`timescale 1ns/100ps
module tb;
  localparam int DP  = 64;
  localparam int SC  = 20;
  logic        core_clk  = 1'b0;
  logic        link_clk  = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        reset_n   = 1'b0;
  logic        sync      = 1'b0;
  logic        fir_sel   = 1'b1;
  logic        cont_sync = 1'b0;
  logic        smp_valid = 1'b0;
  logic [2:0]  ph        = 3'h0;
  logic [31:0] smp_data  = 32'h0;
  logic        sclk, din, dout, rdy_n, cmd_valid;
  logic [7:0]  cmd_byte, got, c;
  logic [31:0] w;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          seed       = 64710;
  int          hits       = 0;
  int          n, h0, off;
  logic [7:0]  tbl [3] = '{8'h11, 8'h12, 8'h10};

  always #20 core_clk = ~core_clk;
  initial #7 forever #24 link_clk = ~link_clk;

  // filter stand-in, a sample every 8 clocks
  always @(posedge core_clk) begin
    ph        <= ph + 3'h1;
    smp_valid <= (ph == 3'h0);
  end
  // capture reported command bytes
  always @(posedge core_clk) begin
    if (cmd_valid === 1'b1) begin
      got  <= cmd_byte;
      hits <= hits + 1;
    end
  end

  asy_core #(.DATA_PERIOD_CLKS(DP), .SINC_SYNC_CLKS(SC)) asy_core_inst (
    .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_sclk(sclk), .i_din(din),
    .o_dout(dout), .o_conversion_ready_n(rdy_n), .i_reset_n(reset_n), .i_sync(sync),
    .i_fir_sel(fir_sel), .i_cont_sync(cont_sync), .i_sample_data(smp_data),
    .i_sample_valid(smp_valid), .o_cmd_byte(cmd_byte), .o_cmd_valid(cmd_valid));
  asy_host asy_host_inst (.i_link_clk(link_clk), .i_dout(dout), .o_sclk(sclk), .o_din(din));

  // clocks from a qualified event to the first ready at the bench's data period
  function automatic int ready_lat(input int extra);
    ready_lat = 62 * DP + ((DP * 251) >> 8) + extra;
  endfunction
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // clocks until the ready strobe falls, bounded
  task automatic wait_fall(input int lim, output int cnt);
    logic p;
    p = rdy_n;
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(posedge core_clk);
      #1;
      if (p === 1'b1 && rdy_n === 1'b0) return;
      p = rdy_n;
    end
    num_errors++;
    $display("mismatch ready fall expected within %0d seen none", lim);
    close_out();
  endtask
  // sync pulse of three clocks high
  task automatic pulse_sync();
    sync <= 1'b1;
    fork
      begin
        repeat (3) @(posedge core_clk);
        sync <= 1'b0;
      end
    join_none
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_fall(ready_lat(468) + 20, n);
    chk_rng("reset to ready", ready_lat(468), ready_lat(468) + 6, n);
    $display("test reset latency done");
    // random bytes, then every command code
    for (int i = 0; i < 9; i++) begin
      c  = (i < 6) ? 8'($random(seed)) : tbl[i-6];
      h0 = hits;
      asy_host_inst.send_byte(c, 8);
      asy_host_inst.gap();
      chk("command byte", {24'h0, c}, {24'h0, got});
      chk("command count", 32'h00000001, 32'(hits - h0));
    end
    $display("test commands done");
    // partial byte dropped by a long idle
    asy_host_inst.send_byte(8'hFF, 4);
    // let the synchronised serial clock read low before counting falls
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 64; i++) wait_fall(2 * DP, n);
    repeat (4) @(posedge core_clk);
    h0 = hits;
    asy_host_inst.send_byte(8'h10, 8);
    asy_host_inst.gap();
    chk("idle restart byte", 32'h10, {24'h0, got});
    chk("idle restart count", 32'h00000001, 32'(hits - h0));
    $display("test idle reset done");
    // first sync in continuous mode is taken
    cont_sync <= 1'b1;
    wait_fall(2 * DP, n);
    pulse_sync();
    wait_fall(ready_lat(466) + 20, n);
    chk_rng("sync to ready", ready_lat(466), ready_lat(466) + 6, n);
    // aligned sync edges keep the period: whole periods after the accepted edge
    off = DP - (n % DP);
    for (int i = 0; i < 3; i++) begin
      repeat (off) @(posedge core_clk);
      pulse_sync();
      wait_fall(2 * DP, n);
      wait_fall(2 * DP, n);
      chk_rng("continuous sync period", DP - 1, DP + 1, n);
    end
    // sinc path: short fixed settling after sync
    cont_sync <= 1'b0;
    fir_sel   <= 1'b0;
    pulse_sync();
    wait_fall(SC + 20, n);
    chk_rng("sinc sync to ready", SC, SC + 6, n);
    fir_sel   <= 1'b1;
    $display("test sync done");
    // armed single reads
    asy_host_inst.send_byte(8'h11, 8);
    asy_host_inst.gap();
    for (int i = 0; i < 3; i++) begin
      smp_data <= (i == 0) ? 32'h80000001 : $random(seed);
      repeat (2 * DP) @(posedge core_clk);
      asy_host_inst.send_byte(8'h12, 8);
      wait_fall(DP + 8, n);
      chk_rng("read command to ready", 1, DP + 8, n);
      chk("msb on ready", {31'h0, smp_data[31]}, {31'h0, dout});
      asy_host_inst.read_word(w);
      chk("read word", smp_data, w);
    end
    $display("test read data done");
    close_out();
  end
endmodule
